// File: pmhte_regs.vh
// What this block does
// - day tick replaces previous-day register with snapshot
// - previous-day timestamp marks interval end, quarter-hour
// - previous-day register readable on request
// - time-of-day preset leaves held timestamp alone
// - start: timestamp zero, seconds zero, invalid true
// - unavailable rise and fall emit timestamped events
// - unavailable events delivered to management
// - severe run needs three successive severe seconds
// - severe run at most nine seconds
// - severe run event carries starting minute
// - single checker sets when count reaches level
// - single checker clears at period end
// - single level rewrite sets or clears state
// - crossing report on false to true
// - crossing detected within one monitor second
// - crossing report names reaching second
// - crossing never clears counting register
// - dual clears at clean low period end
// - dual level rewrite sets; true persists
// - dual clearing report on true to false
// - dual reports carry crossing moment
// - single 15 min or 24 h; dual 15 min
`ifndef PMHTE_REGS_VH
`define PMHTE_REGS_VH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PMHTE_CTRL      12'h000
`define PMHTE_STATUS    12'h004
`define PMHTE_SLVL      12'h008
`define PMHTE_DSET      12'h00C
`define PMHTE_DCLR      12'h010
`define PMHTE_PD_COUNT  12'h014
`define PMHTE_PD_SECS   12'h018
`define PMHTE_PD_STAMP  12'h01C
`define PMHTE_TOD       12'h020
`define PMHTE_EVENTS    12'h024
`define PMHTE_SL_STAMP  12'h028
`define PMHTE_DL_STAMP  12'h02C
`define PMHTE_UA_STAMP  12'h030
`define PMHTE_CS_STAMP  12'h034
// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PMHTE_CTRL_SEL24  0
`define PMHTE_LVL_RST     32'hFFFF_FFFF
`define PMHTE_RUN_MIN     4'h3
`define PMHTE_RUN_MAX     4'h9
`define PMHTE_QH_SECS     17'h0_0384
`define PMHTE_MIN_SECS    32'h0000_003C
`endif

// File: pmhte_top.v
`timescale 1ns/10ps
`include "pmhte_regs.vh"
module pmhte_top #(
  parameter CW = 32
) (
  input  wire          pclk,                 // 125 MHz clock
  input  wire          presetn,              // async reset, low
  input  wire          psel,                 // apb select
  input  wire          penable,              // apb access phase
  input  wire          pwrite,               // apb write
  input  wire [11:0]   paddr,                // apb byte address
  input  wire [31:0]   pwdata,               // apb write data
  output reg  [31:0]   prdata,               // apb read data
  output wire          pready,               // apb ready
  output wire          pslverr,              // apb error
  input  wire          monitor_second_tick,  // one-cycle second strobe
  input  wire          day_boundary_tick,    // one-cycle day strobe
  input  wire          unavailable_state_in, // unavailable level
  input  wire          severely_errored_second, // with second tick
  input  wire [CW-1:0] counter_snapshot_in,  // snapshot count
  input  wire [16:0]   snapshot_seconds_in,  // snapshot interval seconds
  input  wire          snapshot_invalid_in,  // snapshot invalid flag
  input  wire [CW-1:0] running_event_count,  // running count
  output reg           crossing_report,      // single checker pulse
  output reg           dual_crossing_report, // dual checker pulse
  output reg           clearing_report,      // dual clear pulse
  output reg           unavail_begin_event,  // begin pulse
  output reg           unavail_end_event,    // end pulse
  output reg           consecutive_severe_run_event // run pulse
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg          sel24_q;
  reg [CW-1:0] slvl_q;
  reg [CW-1:0] dset_q;
  reg [CW-1:0] dclr_q;
  reg [CW-1:0] previous_day_count;
  reg [16:0]   interval_seconds;
  reg          data_invalid_flag;
  reg [31:0]   pd_stamp_q;
  reg [31:0]   tod_q;
  reg [16:0]   qh_q;
  reg [31:0]   sl_stamp_q;
  reg [31:0]   dl_stamp_q;
  reg [31:0]   ua_stamp_q;
  reg [31:0]   cs_stamp_q;
  reg [31:0]   run_stamp_q;
  reg          sl_state_q;
  reg          dl_state_q;
  reg          ua_seen_q;
  reg          ua_prev_q;
  reg [3:0]    run_q;
  reg [5:0]    events_q;
  reg [5:0]    ev_set;
  wire         wr = psel & penable & pwrite;
  wire         rd_ev = psel & penable & ~pwrite & (paddr == `PMHTE_EVENTS);
  wire         end15 = monitor_second_tick & (qh_q == `PMHTE_QH_SECS - 17'h0_0001);
  wire         end24 = day_boundary_tick;
  wire         sl_end = sel24_q ? end24 : end15;
  wire         wr_sl = wr & (paddr == `PMHTE_SLVL);
  wire         wr_ds = wr & (paddr == `PMHTE_DSET);
  // stamps floored against the time of day itself, so a preset keeps them aligned
  wire [31:0]  tod_min = tod_q - (tod_q % `PMHTE_MIN_SECS);
  wire [31:0]  tod_qh  = tod_q - (tod_q % {15'h0000, `PMHTE_QH_SECS});
  assign pready  = 1'b1;
  assign pslverr = 1'b0;

  // ----------------------------------------------------------------
  // apb writes
  // ----------------------------------------------------------------
  // configuration registers only; the time-of-day preset is in the next block and touches no held stamp
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel24_q <= 1'b0;
      slvl_q  <= `PMHTE_LVL_RST;
      dset_q  <= `PMHTE_LVL_RST;
      dclr_q  <= {CW{1'b0}};
    end else if (wr) begin
      if (paddr == `PMHTE_CTRL) sel24_q <= pwdata[`PMHTE_CTRL_SEL24];
      if (paddr == `PMHTE_SLVL) slvl_q <= pwdata[CW-1:0];
      if (paddr == `PMHTE_DSET) dset_q <= pwdata[CW-1:0];
      if (paddr == `PMHTE_DCLR) dclr_q <= pwdata[CW-1:0];
    end
  end

  // time of day in seconds and quarter-hour period counter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tod_q     <= 32'h0000_0000;
      qh_q      <= 17'h0_0000;
    end else begin
      if (wr && paddr == `PMHTE_TOD) tod_q <= pwdata;
      else if (monitor_second_tick) tod_q <= tod_q + 32'h0000_0001;
      if (end24) qh_q <= 17'h0_0000;
      else if (end15) qh_q <= 17'h0_0000;
      else if (monitor_second_tick) qh_q <= qh_q + 17'h0_0001;
    end
  end

  // ----------------------------------------------------------------
  // previous-day register
  // ----------------------------------------------------------------
  // start values, then overwrite with snapshot each day
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      previous_day_count <= {CW{1'b0}};
      interval_seconds   <= 17'h0_0000;
      data_invalid_flag  <= 1'b1;
      pd_stamp_q         <= 32'h0000_0000;
    end else if (end24) begin
      previous_day_count <= counter_snapshot_in;
      interval_seconds   <= snapshot_seconds_in;
      data_invalid_flag  <= snapshot_invalid_in;
      // end stamp rounded down to a quarter hour of the clock
      pd_stamp_q <= tod_qh;
    end
  end

  // ----------------------------------------------------------------
  // unavailable events and severe runs
  // ----------------------------------------------------------------
  // edge events stamped to the minute; runs of three or more
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ua_prev_q   <= 1'b0;
      ua_stamp_q  <= 32'h0000_0000;
      run_q       <= 4'h0;
      run_stamp_q <= 32'h0000_0000;
      cs_stamp_q  <= 32'h0000_0000;
      unavail_begin_event <= 1'b0;
      unavail_end_event   <= 1'b0;
      consecutive_severe_run_event <= 1'b0;
    end else begin
      ua_prev_q <= unavailable_state_in;
      unavail_begin_event <= unavailable_state_in & ~ua_prev_q;
      unavail_end_event   <= ~unavailable_state_in & ua_prev_q;
      if (unavailable_state_in != ua_prev_q)
        ua_stamp_q <= tod_min;
      consecutive_severe_run_event <= 1'b0;
      if (monitor_second_tick) begin
        if (!severely_errored_second) run_q <= 4'h0;
        else if (run_q != `PMHTE_RUN_MAX) run_q <= run_q + 4'h1;
        if (severely_errored_second && run_q == 4'h0)
          run_stamp_q <= tod_min;
        if (severely_errored_second && run_q == `PMHTE_RUN_MIN - 4'h1) begin
          consecutive_severe_run_event <= 1'b1;
          cs_stamp_q <= run_stamp_q;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // threshold checkers
  // ----------------------------------------------------------------
  // state never touches the counters, only reads them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sl_state_q <= 1'b0;
      dl_state_q <= 1'b0;
      ua_seen_q  <= 1'b0;
      sl_stamp_q <= 32'h0000_0000;
      dl_stamp_q <= 32'h0000_0000;
      crossing_report      <= 1'b0;
      dual_crossing_report <= 1'b0;
      clearing_report      <= 1'b0;
    end else begin
      crossing_report      <= 1'b0;
      dual_crossing_report <= 1'b0;
      clearing_report      <= 1'b0;
      // single level, checked each second or on rewrite
      if (sl_end) begin
        sl_state_q <= 1'b0;
      end else if (wr_sl) begin
        if (pwdata[CW-1:0] > running_event_count)
          sl_state_q <= 1'b0;
        else if (!sl_state_q) begin
          sl_state_q <= 1'b1;
          crossing_report <= 1'b1;
          sl_stamp_q <= tod_q;
        end
      end else if (monitor_second_tick && !sl_state_q &&
                   running_event_count >= slvl_q) begin
        sl_state_q <= 1'b1;
        crossing_report <= 1'b1;
        sl_stamp_q <= tod_q;
      end
      // dual level, 15 minute periods only
      if (unavailable_state_in) ua_seen_q <= 1'b1;
      if (end15) ua_seen_q <= unavailable_state_in;
      if (end15 && dl_state_q && !ua_seen_q && !unavailable_state_in &&
          running_event_count <= dclr_q) begin
        dl_state_q <= 1'b0;
        clearing_report <= 1'b1;
        dl_stamp_q <= tod_q;
      end else if (!dl_state_q &&
                   ((wr_ds && pwdata[CW-1:0] <= running_event_count) ||
                    (monitor_second_tick && running_event_count >= dset_q))) begin
        dl_state_q <= 1'b1;
        dual_crossing_report <= 1'b1;
        dl_stamp_q <= tod_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // sticky event flags, cleared by read; a new set wins
  // ----------------------------------------------------------------
  always @* begin
    ev_set = {consecutive_severe_run_event, unavail_end_event, unavail_begin_event,
              clearing_report, dual_crossing_report, crossing_report};
  end

  // management delivery log
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) events_q <= 6'h00;
    else events_q <= (rd_ev ? 6'h00 : events_q) | ev_set;
  end

  // ----------------------------------------------------------------
  // apb reads
  // ----------------------------------------------------------------
  // registered read data during setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `PMHTE_CTRL:     prdata <= {31'h0000_0000, sel24_q};
        `PMHTE_STATUS:   prdata <= {26'h000_0000, run_q, dl_state_q, sl_state_q};
        `PMHTE_SLVL:     prdata <= slvl_q;
        `PMHTE_DSET:     prdata <= dset_q;
        `PMHTE_DCLR:     prdata <= dclr_q;
        `PMHTE_PD_COUNT: prdata <= previous_day_count;
        `PMHTE_PD_SECS:  prdata <= {data_invalid_flag, 14'h0000, interval_seconds};
        `PMHTE_PD_STAMP: prdata <= pd_stamp_q;
        `PMHTE_TOD:      prdata <= tod_q;
        `PMHTE_EVENTS:   prdata <= {26'h000_0000, events_q | ev_set};
        `PMHTE_SL_STAMP: prdata <= sl_stamp_q;
        `PMHTE_DL_STAMP: prdata <= dl_stamp_q;
        `PMHTE_UA_STAMP: prdata <= ua_stamp_q;
        `PMHTE_CS_STAMP: prdata <= cs_stamp_q;
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// File: pmhte_far.sv
`timescale 1ns/10ps
// ----------------------------------------
// second tick and severe-second source
// ----------------------------------------
module pmhte_far #(
  parameter GAP = 8
) (
  input  logic pclk,                    // clock
  input  logic presetn,                 // async reset, low
  input  logic sev_plan,                // severe flag for coming ticks
  input  logic ua,                      // unavailable level
  output logic monitor_second_tick,     // one-cycle strobe
  output logic severely_errored_second  // valid with tick only
);
  int cnt;
  // one strobe every GAP cycles
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 0;
    else cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
  end
  assign monitor_second_tick = (cnt == GAP - 1);
  // forced low in unavailable time, churned between ticks
  assign severely_errored_second = monitor_second_tick ? (sev_plan & ~ua) : ~sev_plan;
endmodule

// File: pmhte_props.sv
`timescale 1ns/10ps
module pmhte_props (
  input logic pclk,                        // clock
  input logic presetn,                     // async reset, low
  input logic psel,                        // apb select
  input logic penable,                     // apb access
  input logic pwrite,                      // apb write
  input logic pready,                      // apb ready
  input logic pslverr,                     // apb error
  input logic monitor_second_tick,         // second strobe
  input logic severely_errored_second,     // severe flag
  input logic unavailable_state_in,        // unavailable level
  input logic crossing_report,             // single crossing
  input logic dual_crossing_report,        // dual crossing
  input logic clearing_report,             // dual clear
  input logic unavail_begin_event,         // begin pulse
  input logic unavail_end_event,           // end pulse
  input logic consecutive_severe_run_event // run pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_ua_rise;
    $rose(unavailable_state_in);
  endsequence
  sequence s_ua_fall;
    $fell(unavailable_state_in);
  endsequence
  property p_ready; pready && !pslverr; endproperty
  a_ready: assert property (p_ready) else $error("apb answer wrong");
  property p_ua_begin; s_ua_rise |=> unavail_begin_event; endproperty
  a_ua_begin: assert property (p_ua_begin) else $error("no begin event");
  property p_ua_end; s_ua_fall |=> unavail_end_event; endproperty
  a_ua_end: assert property (p_ua_end) else $error("no end event");
  property p_ua_pulse; unavail_begin_event |=> !unavail_begin_event; endproperty
  a_ua_pulse: assert property (p_ua_pulse) else $error("begin event too long");
  property p_run_cause;
    consecutive_severe_run_event |-> $past(monitor_second_tick && severely_errored_second);
  endproperty
  a_run_cause: assert property (p_run_cause) else $error("run without severe tick");
  property p_cross_cause;
    crossing_report |-> $past(monitor_second_tick || (psel && penable && pwrite));
  endproperty
  a_cross_cause: assert property (p_cross_cause) else $error("crossing uncaused");
  property p_dual_cause;
    dual_crossing_report |-> $past(monitor_second_tick || (psel && penable && pwrite));
  endproperty
  a_dual_cause: assert property (p_dual_cause) else $error("dual crossing uncaused");
  property p_clear_cause; clearing_report |-> $past(monitor_second_tick); endproperty
  a_clear_cause: assert property (p_clear_cause) else $error("clear off tick");
  property p_cross_once; crossing_report |=> !crossing_report; endproperty
  a_cross_once: assert property (p_cross_once) else $error("crossing repeated");
endmodule
bind pmhte_top pmhte_props u_props (.*);

// File: test_pm_history_threshold_events.sv
`timescale 1ns/10ps
`include "pmhte_regs.vh"
module test_pm_history_threshold_events;
  logic        pclk, presetn, psel, penable, pwrite, day_tick, ua, sev_plan, sinv, tick, sev;
  logic        pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, snap, cnt, v;
  logic [16:0] ssecs;
  int          n_fail, n_checks;
  pmhte_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .monitor_second_tick(tick), .day_boundary_tick(day_tick),
    .unavailable_state_in(ua), .severely_errored_second(sev), .counter_snapshot_in(snap),
    .snapshot_seconds_in(ssecs), .snapshot_invalid_in(sinv), .running_event_count(cnt),
    .crossing_report(), .dual_crossing_report(), .clearing_report(),
    .unavail_begin_event(), .unavail_end_event(), .consecutive_severe_run_event());
  pmhte_far far (.pclk(pclk), .presetn(presetn), .sev_plan(sev_plan), .ua(ua),
    .monitor_second_tick(tick), .severely_errored_second(sev));
  // one apb transfer, then settle time for pulses
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    begin
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      v = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
  // masked read and compare
  task rdchk(input string nm, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    begin
      xfer(1'b0, a, 32'h0000_0000);
      n_checks++;
      if ((v & m) !== e) begin
        n_fail++;
        $display("BAD %s expected %h seen %h", nm, e, v & m);
      end
    end
  endtask
  task ticks(input int n);
    begin
      repeat (n) begin
        do @(posedge pclk); while (tick !== 1'b1);
      end
      repeat (2) @(posedge pclk);
    end
  endtask
  // day strobe with a new snapshot
  task day(input logic [31:0] s, input logic i);
    begin
      snap     <= s;
      sinv     <= i;
      day_tick <= 1'b1;
      @(posedge pclk);
      day_tick <= 1'b0;
      @(posedge pclk);
      rdchk("pd_count", `PMHTE_PD_COUNT, 32'hFFFF_FFFF, s);
      rdchk("pd_secs", `PMHTE_PD_SECS, 32'hFFFF_FFFF, {i, 14'h0000, ssecs});
      rdchk("pd_stamp", `PMHTE_PD_STAMP, 32'hFFFF_FFFF, 32'h0000_0E10);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    #(8 * 30000);
    n_fail++;
    summarize;
  end
  // test sequence
  initial begin
    {psel, penable, pwrite, day_tick, ua, sev_plan, sinv} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    snap = 32'h0000_0000;
    ssecs = 17'h1_5180;
    cnt = 32'h0000_0000;
    n_fail = 0;
    n_checks = 0;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("pd_count", `PMHTE_PD_COUNT, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk("pd_secs", `PMHTE_PD_SECS, 32'hFFFF_FFFF, 32'h8000_0000);
    rdchk("slvl", `PMHTE_SLVL, 32'hFFFF_FFFF, `PMHTE_LVL_RST);
    rdchk("unmapped", 12'h0FC, 32'hFFFF_FFFF, 32'h0000_0000);
    xfer(1'b1, `PMHTE_TOD, 32'h0000_1000);
    rdchk("pd_stamp", `PMHTE_PD_STAMP, 32'hFFFF_FFFF, 32'h0000_0000);
    day(32'h1234_5678, 1'b0);
    day(32'hFFFF_0001, 1'b1);
    xfer(1'b1, `PMHTE_TOD, 32'h0000_1000);
    rdchk("pd_stamp_kept", `PMHTE_PD_STAMP, 32'hFFFF_FFFF, 32'h0000_0E10);
    $display("test history done");
    rdchk("events", `PMHTE_EVENTS, 32'h0000_003F, 32'h0000_0000);
    ua <= 1'b1;
    ticks(2);
    ua <= 1'b0;
    ticks(2);
    rdchk("ua_events", `PMHTE_EVENTS, 32'h0000_0018, 32'h0000_0018);
    rdchk("ua_stamp", `PMHTE_UA_STAMP, 32'hFFFF_FFFF, 32'h0000_0FF0);
    sev_plan <= 1'b1;
    ticks(2);
    sev_plan <= 1'b0;
    ticks(1);
    rdchk("run_two", `PMHTE_EVENTS, 32'h0000_0020, 32'h0000_0000);
    sev_plan <= 1'b1;
    ticks(3);
    sev_plan <= 1'b0;
    ticks(1);
    rdchk("run_three", `PMHTE_EVENTS, 32'h0000_0020, 32'h0000_0020);
    rdchk("run_stamp", `PMHTE_CS_STAMP, 32'hFFFF_FFFF, 32'h0000_0FF0);
    $display("test events done");
    cnt <= 32'h0000_0005;
    xfer(1'b1, `PMHTE_SLVL, 32'h0000_0005);
    rdchk("sl_set", `PMHTE_STATUS, 32'h0000_0001, 32'h0000_0001);
    ticks(2);
    rdchk("sl_rep", `PMHTE_EVENTS, 32'h0000_0001, 32'h0000_0001);
    xfer(1'b1, `PMHTE_SLVL, 32'h0000_0006);
    rdchk("sl_clr", `PMHTE_STATUS, 32'h0000_0001, 32'h0000_0000);
    cnt <= 32'h0000_0006;
    ticks(1);
    rdchk("sl_tick", `PMHTE_STATUS, 32'h0000_0001, 32'h0000_0001);
    rdchk("sl_rep2", `PMHTE_EVENTS, 32'h0000_0001, 32'h0000_0001);
    xfer(1'b1, `PMHTE_DSET, 32'h0000_0007);
    rdchk("dl_high", `PMHTE_STATUS, 32'h0000_0002, 32'h0000_0000);
    xfer(1'b1, `PMHTE_DSET, 32'h0000_0006);
    xfer(1'b1, `PMHTE_DSET, 32'h0000_0009);
    rdchk("dl_keep", `PMHTE_STATUS, 32'h0000_0002, 32'h0000_0002);
    rdchk("dl_rep", `PMHTE_EVENTS, 32'h0000_0002, 32'h0000_0002);
    $display("test levels done");
    cnt <= 32'h0000_0000;
    ticks(1800);
    rdchk("period_end", `PMHTE_STATUS, 32'h0000_0003, 32'h0000_0000);
    rdchk("dl_clr_rep", `PMHTE_EVENTS, 32'h0000_0004, 32'h0000_0004);
    $display("test periods done");
    summarize;
  end
endmodule
